// ### hdl/dual_8bit_timer_counter.sv
`timescale 1ns/1ns
module dual_8bit_timer_counter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slowClkEn,
  input wire logic slowState,
  input wire logic prescalerSelect,
  input wire logic [7:0] counterControlLo,
  input wire logic [7:0] counterControlHi,
  input wire logic [7:0] compareValueLo,
  input wire logic [7:0] compareValueHi,
  input wire logic eventInputPinLo,
  input wire logic eventInputPinHi,
  output logic matchIrqLo,
  output logic matchIrqHi,
  output logic dividerOutPinLo,
  output logic dividerOutPinHi,
  output logic [7:0] countLo,
  output logic [7:0] countHi
);
  tick_if tk ();
  prescaler u_pre (
    .clk(clk),
    .resetn(resetn),
    .slowClkEn(slowClkEn),
    .tk(tk)
  );

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} run_t;

  // rising edge of a tap, slow tap only advances on slow ticks
  function automatic logic tapEdge(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : tapEdge

  function automatic logic pickTick(input logic [2:0] ck, input logic [3:0] edges,
                                    input logic slowEdge, input logic selSlow,
                                    input logic inSlow, input logic pinFall);
    logic r;
    r = 1'b0;
    if (ck == tc_pkg::CK_PIN) r = pinFall;
    else if (inSlow) r = (ck == tc_pkg::CK_DIV11) & slowEdge;
    else begin
      unique case (ck)
        tc_pkg::CK_DIV11: r = selSlow ? slowEdge : edges[0];
        tc_pkg::CK_DIV7: r = edges[1];
        tc_pkg::CK_DIV5: r = edges[2];
        tc_pkg::CK_DIV3: r = edges[3];
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction : pickTick

  // synchronisers and edge history
  logic [1:0] pinLoSync_ff, pinHiSync_ff, nxt_pinLoSync, nxt_pinHiSync;
  logic pinLoPrev_ff, pinHiPrev_ff;
  logic [3:0] tapPrev_ff, nxt_tapPrev;
  logic slowPrev_ff, nxt_slowPrev;
  logic [3:0] taps, edges;
  logic slowEdge, fallLo, fallHi;

  always_comb begin
    taps = {tk.fastTaps[tc_pkg::TAP3], tk.fastTaps[tc_pkg::TAP5],
            tk.fastTaps[tc_pkg::TAP7], tk.fastTaps[tc_pkg::TAP11]};
    for (int i = 0; i < 4; i++) edges[i] = tapEdge(taps[i], tapPrev_ff[i]);
    slowEdge = tapEdge(tk.slowTaps[tc_pkg::SLOW_TAP3], slowPrev_ff);
    nxt_tapPrev = taps;
    nxt_slowPrev = tk.slowTaps[tc_pkg::SLOW_TAP3];
    nxt_pinLoSync = {pinLoSync_ff[0], eventInputPinLo};
    nxt_pinHiSync = {pinHiSync_ff[0], eventInputPinHi};
    fallLo = pinLoPrev_ff & ~pinLoSync_ff[1];
    fallHi = pinHiPrev_ff & ~pinHiSync_ff[1];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pinLoSync_ff <= 2'b11;
      pinHiSync_ff <= 2'b11;
      pinLoPrev_ff <= 1'b1;
      pinHiPrev_ff <= 1'b1;
      tapPrev_ff <= '0;
      slowPrev_ff <= 1'b0;
    end else begin
      pinLoSync_ff <= nxt_pinLoSync;
      pinHiSync_ff <= nxt_pinHiSync;
      pinLoPrev_ff <= pinLoSync_ff[1];
      pinHiPrev_ff <= pinHiSync_ff[1];
      tapPrev_ff <= nxt_tapPrev;
      slowPrev_ff <= nxt_slowPrev;
    end
  end

  // counters
  logic [7:0] cntLo_ff, cntHi_ff, nxt_cntLo, nxt_cntHi;
  logic ffLo_ff, ffHi_ff, nxt_ffLo, nxt_ffHi;
  logic irqLo_ff, irqHi_ff, nxt_irqLo, nxt_irqHi;
  logic pinOutLo_ff, pinOutHi_ff, nxt_pinOutLo, nxt_pinOutHi;
  run_t stLo_ff, stHi_ff, nxt_stLo, nxt_stHi;
  logic runLo, runHi, cascade, tickLo, tickHi, matchLo, matchHi, match16;
  logic [2:0] modeLo, modeHi;
  // last seen init bits: a stopped flip-flop only reloads on start or when software rewrites the bit
  logic initLo, initHi, initLoPrev_ff, initHiPrev_ff, nxt_initLoPrev, nxt_initHiPrev;

  always_comb begin
    runLo = counterControlLo[tc_pkg::CR_RUN_BIT];
    runHi = counterControlHi[tc_pkg::CR_RUN_BIT];
    modeLo = counterControlLo[tc_pkg::CR_MODE_MSB:tc_pkg::CR_MODE_LSB];
    modeHi = counterControlHi[tc_pkg::CR_MODE_MSB:tc_pkg::CR_MODE_LSB];
    initLo = counterControlLo[tc_pkg::CR_FF_BIT];
    initHi = counterControlHi[tc_pkg::CR_FF_BIT];
    nxt_initLoPrev = initLo;
    nxt_initHiPrev = initHi;
    // upper byte mode 1xx makes the pair one 16-bit counter, run from the upper run bit
    cascade = modeHi[2];
    tickLo = pickTick(counterControlLo[tc_pkg::CR_CK_MSB:tc_pkg::CR_CK_LSB], edges, slowEdge,
                      prescalerSelect, slowState, fallLo);
    tickHi = pickTick(counterControlHi[tc_pkg::CR_CK_MSB:tc_pkg::CR_CK_LSB], edges, slowEdge,
                      prescalerSelect, slowState, fallHi);
    // compare is read live, so a write while running takes effect at once
    matchLo = tickLo && (cntLo_ff + 8'h01 == compareValueLo);
    matchHi = tickHi && (cntHi_ff + 8'h01 == compareValueHi);
    match16 = tickLo && ({cntHi_ff, cntLo_ff} + 16'h0001 == {compareValueHi, compareValueLo});
    nxt_stLo = (cascade ? runHi : runLo) ? ST_RUN : ST_IDLE;
    nxt_stHi = runHi ? ST_RUN : ST_IDLE;
    nxt_cntLo = cntLo_ff;
    nxt_cntHi = cntHi_ff;
    nxt_ffLo = ffLo_ff;
    nxt_ffHi = ffHi_ff;
    nxt_irqLo = 1'b0;
    nxt_irqHi = 1'b0;
    if (cascade) begin
      if (stHi_ff == ST_IDLE) begin
        {nxt_cntHi, nxt_cntLo} = 16'h0000;
      end else if (match16) begin
        {nxt_cntHi, nxt_cntLo} = 16'h0000;
        nxt_irqHi = 1'b1;
      end else if (tickLo) begin
        // lower byte overflow clocks the upper byte
        nxt_cntLo = cntLo_ff + 8'h01;
        if (cntLo_ff == 8'hFF) nxt_cntHi = cntHi_ff + 8'h01;
      end
    end else begin
      unique case (stLo_ff)
        ST_IDLE: begin
          nxt_cntLo = 8'h00;
        end
        ST_RUN: begin
          if (matchLo) begin
            nxt_cntLo = 8'h00;
            nxt_irqLo = 1'b1;
            if (modeLo == tc_pkg::MODE_DIVIDER8) nxt_ffLo = ~ffLo_ff;
          end else if (tickLo) nxt_cntLo = cntLo_ff + 8'h01;
        end
      endcase
      unique case (stHi_ff)
        ST_IDLE: begin
          nxt_cntHi = 8'h00;
        end
        ST_RUN: begin
          if (matchHi) begin
            nxt_cntHi = 8'h00;
            nxt_irqHi = 1'b1;
            if (modeHi == tc_pkg::MODE_DIVIDER8) nxt_ffHi = ~ffHi_ff;
          end else if (tickHi) nxt_cntHi = cntHi_ff + 8'h01;
        end
      endcase
    end
    // stopping freezes the flip-flop: the init bit is only sampled while already idle
    if (stLo_ff == ST_RUN && nxt_stLo == ST_IDLE) nxt_ffLo = ffLo_ff;
    if (stHi_ff == ST_RUN && nxt_stHi == ST_IDLE) nxt_ffHi = ffHi_ff;
    // loading on every idle cycle would undo the held level; load on start or on a rewrite only
    if (stLo_ff == ST_IDLE && (nxt_stLo == ST_RUN || initLo != initLoPrev_ff)) nxt_ffLo = initLo;
    if (stHi_ff == ST_IDLE && (nxt_stHi == ST_RUN || initHi != initHiPrev_ff)) nxt_ffHi = initHi;
    nxt_pinOutLo = ~nxt_ffLo;
    nxt_pinOutHi = ~nxt_ffHi;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stLo_ff <= ST_IDLE;
      stHi_ff <= ST_IDLE;
      cntLo_ff <= 8'h00;
      cntHi_ff <= 8'h00;
      ffLo_ff <= 1'b0;
      ffHi_ff <= 1'b0;
      irqLo_ff <= 1'b0;
      irqHi_ff <= 1'b0;
      pinOutLo_ff <= 1'b1;
      pinOutHi_ff <= 1'b1;
      initLoPrev_ff <= 1'b0;
      initHiPrev_ff <= 1'b0;
    end else begin
      initLoPrev_ff <= nxt_initLoPrev;
      initHiPrev_ff <= nxt_initHiPrev;
      stLo_ff <= nxt_stLo;
      stHi_ff <= nxt_stHi;
      cntLo_ff <= nxt_cntLo;
      cntHi_ff <= nxt_cntHi;
      ffLo_ff <= nxt_ffLo;
      ffHi_ff <= nxt_ffHi;
      irqLo_ff <= nxt_irqLo;
      irqHi_ff <= nxt_irqHi;
      pinOutLo_ff <= nxt_pinOutLo;
      pinOutHi_ff <= nxt_pinOutHi;
    end
  end

  assign matchIrqLo = irqLo_ff;
  assign matchIrqHi = irqHi_ff;
  assign dividerOutPinLo = pinOutLo_ff;
  assign dividerOutPinHi = pinOutHi_ff;
  assign countLo = cntLo_ff;
  assign countHi = cntHi_ff;

  // checks
  sequence matchLoSeq;
    !cascade && stLo_ff == ST_RUN && matchLo;
  endsequence
  chk_irq_pulse_lo: assert property (@(posedge clk) disable iff (!resetn)
    matchLoSeq |=> matchIrqLo ##1 !matchIrqLo) else $error("irq lo not one-cycle pulse");
  chk_count_clear_lo: assert property (@(posedge clk) disable iff (!resetn)
    matchLoSeq |=> countLo == 8'h00) else $error("count lo not cleared on match");
  chk_div_toggle: assert property (@(posedge clk) disable iff (!resetn)
    (matchLoSeq and (modeLo == tc_pkg::MODE_DIVIDER8)) |=> dividerOutPinLo != $past(dividerOutPinLo))
    else $error("divider pin did not toggle");
  chk_pin_inverse: assert property (@(posedge clk) disable iff (!resetn)
    dividerOutPinHi == ~ffHi_ff) else $error("divider pin not inverse");
  chk_stop_zero: assert property (@(posedge clk) disable iff (!resetn)
    stHi_ff == ST_IDLE |=> countHi == 8'h00) else $error("stopped counter not zero");
  chk_no_irq_idle: assert property (@(posedge clk) disable iff (!resetn)
    stLo_ff == ST_IDLE && !cascade |=> !matchIrqLo) else $error("irq while stopped");
  chk_stop_hold: assert property (@(posedge clk) disable iff (!resetn)
    !cascade && stLo_ff == ST_RUN && !runLo |=> $stable(dividerOutPinLo))
    else $error("pin changed on stop");
  chk_event_step: assert property (@(posedge clk) disable iff (!resetn)
    !cascade && stHi_ff == ST_RUN && tickHi && !matchHi |=> countHi == $past(countHi) + 8'h01)
    else $error("count hi did not step");
  chk_cascade_carry: assert property (@(posedge clk) disable iff (!resetn)
    cascade && stHi_ff == ST_RUN && tickLo && !match16 && cntLo_ff == 8'hFF |=> countLo == 8'h00)
    else $error("cascade carry wrong");

  // either byte as a free 8-bit counter
  sequence matchHiSeq;
    !cascade && stHi_ff == ST_RUN && matchHi;
  endsequence
  chk_irq_pulse_hi: assert property (@(posedge clk) disable iff (!resetn)
    matchHiSeq |=> matchIrqHi ##1 !matchIrqHi)
    else $error("irq hi not one-cycle pulse");
  chk_count_clear_hi: assert property (@(posedge clk) disable iff (!resetn)
    matchHiSeq |=> countHi == 8'h00)
    else $error("count hi not cleared on match");
  chk_pin_inv_lo: assert property (@(posedge clk) disable iff (!resetn)
    dividerOutPinLo == !ffLo_ff)
    else $error("divider pin lo not inverse");
  chk_stop_zero_lo: assert property (@(posedge clk) disable iff (!resetn)
    !cascade && stLo_ff == ST_IDLE |=> countLo == 8'h00)
    else $error("stopped counter lo not zero");
  chk_timer_step_lo: assert property (@(posedge clk) disable iff (!resetn)
    !cascade && stLo_ff == ST_RUN && tickLo && !matchLo |=> countLo == $past(countLo) + 8'h01)
    else $error("count lo did not step");
  // 16-bit match clears both bytes and pulses the upper interrupt
  sequence match16Seq;
    cascade && stHi_ff == ST_RUN && match16;
  endsequence
  chk_cascade_match: assert property (@(posedge clk) disable iff (!resetn)
    match16Seq |=> countLo == 8'h00 && countHi == 8'h00 && matchIrqHi)
    else $error("cascade match did not clear");
  // starting from idle takes the init bit into the flip-flop
  sequence startLoSeq;
    !cascade && stLo_ff == ST_IDLE && nxt_stLo == ST_RUN;
  endsequence
  chk_start_load: assert property (@(posedge clk) disable iff (!resetn)
    startLoSeq |=> dividerOutPinLo == !$past(counterControlLo[tc_pkg::CR_FF_BIT]))
    else $error("init bit not loaded on start");
  chk_idle_hold: assert property (@(posedge clk) disable iff (!resetn)
    !cascade && stLo_ff == ST_IDLE && nxt_stLo == ST_IDLE && initLo == initLoPrev_ff
    |=> $stable(dividerOutPinLo))
    else $error("stopped pin moved without rewrite");
  chk_rewrite_load: assert property (@(posedge clk) disable iff (!resetn)
    !cascade && stLo_ff == ST_IDLE && initLo != initLoPrev_ff |=> dividerOutPinLo == !$past(initLo))
    else $error("rewrite of init bit not applied");
endmodule : dual_8bit_timer_counter

// ### hdl/prescaler.sv
`timescale 1ns/1ns
module prescaler (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slowClkEn,
  tick_if.src tk
);
  logic [tc_pkg::PRE_W-1:0] fast_ff, nxt_fast;
  logic [tc_pkg::SLOW_W-1:0] slow_ff, nxt_slow;
  // slow clock arrives as an enable pulse, so the whole chain stays on clk
  always_comb begin
    nxt_fast = fast_ff + 1'b1;
    nxt_slow = slowClkEn ? slow_ff + 1'b1 : slow_ff;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fast_ff <= '0;
      slow_ff <= '0;
    end else begin
      fast_ff <= nxt_fast;
      slow_ff <= nxt_slow;
    end
  end
  assign tk.fastTaps = fast_ff;
  assign tk.slowTaps = slow_ff;
  assign tk.fastTick = 1'b1;
  assign tk.slowTick = slowClkEn;
endmodule : prescaler

// ### hdl/tc_pkg.sv
package tc_pkg;
  // control register fields
  localparam int CR_MODE_LSB = 0;
  localparam int CR_MODE_MSB = 2;
  localparam int CR_RUN_BIT = 3;
  localparam int CR_CK_LSB = 4;
  localparam int CR_CK_MSB = 6;
  localparam int CR_FF_BIT = 7;
  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'hFF;
  // mode codes
  localparam logic [2:0] MODE_TIMER8 = 3'h0;
  localparam logic [2:0] MODE_DIVIDER8 = 3'h1;
  localparam logic [2:0] MODE_TIMER16 = 3'h4;
  // source clock codes
  localparam logic [2:0] CK_DIV11 = 3'h0;
  localparam logic [2:0] CK_DIV7 = 3'h1;
  localparam logic [2:0] CK_DIV5 = 3'h2;
  localparam logic [2:0] CK_DIV3 = 3'h3;
  localparam logic [2:0] CK_PIN = 3'h7;
  // prescaler taps
  localparam int PRE_W = 11;
  localparam int TAP11 = 10;
  localparam int TAP7 = 6;
  localparam int TAP5 = 4;
  localparam int TAP3 = 2;
  localparam int SLOW_TAP3 = 2;
  localparam int SLOW_W = 3;
endpackage : tc_pkg

// ### hdl/tick_if.sv
`timescale 1ns/1ns
interface tick_if;
  logic [tc_pkg::PRE_W-1:0] fastTaps;
  logic [tc_pkg::SLOW_W-1:0] slowTaps;
  logic fastTick;
  logic slowTick;
  modport src (output fastTaps, output slowTaps, output fastTick, output slowTick);
  modport snk (input fastTaps, input slowTaps, input fastTick, input slowTick);
endinterface : tick_if

// ### verification/event_src.sv
`timescale 1ns/1ns
module event_src (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] num,
  output logic pin,
  output logic busy
);
  int left = 0;
  int ph = 0;
  initial pin = 1'b1;
  assign busy = (left != 0);
  // each level lasts 10 cycles, well above two machine cycles
  // idle level is high, as a pulled-up pin rests there between pulses
  always @(posedge clk) begin
    if (start && left == 0) begin
      left <= num;
      ph <= 0;
    end else if (left != 0) begin
      ph <= ph + 1;
      if (ph == 9) pin <= 1'b0;
      if (ph == 19) begin
        pin <= 1'b1;
        ph <= 0;
        left <= left - 1;
      end
    end
  end
endmodule : event_src

// ### verification/tb_dual_8bit_timer_counter.sv
`timescale 1ns/1ns
module tb_dual_8bit_timer_counter;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic slowClkEn = 1'b0;
  logic [7:0] ctrlLo = 8'h00, ctrlHi = 8'h00, cmpLo = 8'h01, cmpHi = 8'h01;
  logic evStart = 1'b0;
  logic [7:0] evNum = 8'h00;
  logic evPin, evBusy, irqLo, irqHi, pinLo, pinHi;
  logic [7:0] countLo, countHi;
  logic p1, p2;
  int mismatches = 0, n_checks = 0, n, i;
  typedef struct {logic [7:0] ctrl; logic [7:0] cmp; int period; logic dv;} row_t;
  // compares kept in 1..255 and init bit 0 in timer rows
  row_t rows[5] = '{'{8'h30, 8'h01, 8, 1'b0}, '{8'h30, 8'h05, 40, 1'b0}, '{8'h20, 8'h03, 96, 1'b0},
                    '{8'h10, 8'h02, 256, 1'b0}, '{8'h31, 8'h04, 32, 1'b1}};
  always #25 clk = ~clk;
  always @(posedge clk) slowClkEn <= ($time % 400) < 50;
  dual_8bit_timer_counter u_dual_8bit_timer_counter (.clk(clk), .resetn(resetn), .slowClkEn(slowClkEn),
    .slowState(1'b0), .prescalerSelect(1'b0), .counterControlLo(ctrlLo), .counterControlHi(ctrlHi),
    .compareValueLo(cmpLo), .compareValueHi(cmpHi), .eventInputPinLo(1'b1), .eventInputPinHi(evPin),
    .matchIrqLo(irqLo), .matchIrqHi(irqHi), .dividerOutPinLo(pinLo), .dividerOutPinHi(pinHi),
    .countLo(countLo), .countHi(countHi));
  event_src u_event_src (.clk(clk), .start(evStart), .num(evNum), .pin(evPin), .busy(evBusy));
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkn(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      mismatches++;
      $display("BAD %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask : chkn
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_irq(input bit hi, output int cnt);
    cnt = 0;
    do begin
      cyc(1);
      cnt++;
    end while (!(hi ? irqHi === 1'b1 : irqLo === 1'b1) && cnt < 5000);
    if (cnt >= 5000) begin
      mismatches++;
      $display("BAD %0t no match pulse", $time);
      complete_run();
    end
  endtask : wait_irq
  initial begin
    cyc(2);
    chk8(countLo | countHi, 8'h00);
    chk8({4'h0, pinLo, pinHi, irqLo, irqHi}, 8'h0C);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      ctrlLo <= rows[i].ctrl;
      cmpLo <= rows[i].cmp;
      cyc(2);
      ctrlLo <= rows[i].ctrl | 8'h08;
      wait_irq(1'b0, n);
      chk8(countLo, 8'h00);
      p1 = pinLo;
      wait_irq(1'b0, n);
      chkn(n, rows[i].period);
      p2 = pinLo;
      chk8({7'h00, p2}, {7'h00, (rows[i].dv ? ~p1 : 1'b1)});
      if (i < 4) ctrlLo <= rows[i].ctrl;
    end
    ctrlLo <= 8'h31;
    cyc(3);
    chk8(countLo, 8'h00);
    chk8(pinLo, p2);
    cyc(3);
    chk8(pinLo, p2);
    ctrlLo <= 8'hB1;
    cyc(3);
    chk8(pinLo, 1'b0);
    ctrlLo <= 8'h31;
    cyc(3);
    chk8(pinLo, 1'b1);
    ctrlLo <= 8'h30;
    cmpLo <= 8'hC8;
    cyc(2);
    ctrlLo <= 8'h38;
    cyc(20);
    cmpLo <= 8'h05;
    wait_irq(1'b0, n);
    chkn(n < 45, 1);
    ctrlLo <= 8'h30;
    ctrlHi <= 8'h70;
    cmpHi <= 8'h03;
    cyc(2);
    ctrlHi <= 8'h78;
    evNum <= 8'h02;
    evStart <= 1'b1;
    cyc(1);
    evStart <= 1'b0;
    cyc(50);
    chk8(countHi, 8'h02);
    evNum <= 8'h01;
    evStart <= 1'b1;
    cyc(1);
    evStart <= 1'b0;
    wait_irq(1'b1, n);
    chkn(n < 40, 1);
    chk8(countHi, 8'h00);
    ctrlHi <= 8'h04;
    ctrlLo <= 8'h33;
    cmpLo <= 8'h02;
    cmpHi <= 8'h01; // 16-bit compare 258 within range
    cyc(2);
    ctrlHi <= 8'h0C;
    wait_irq(1'b1, n);
    wait_irq(1'b1, n);
    chkn(n, 2064);
    resetn <= 1'b0;
    cyc(2);
    chk8(countLo | countHi, 8'h00);
    chk8({6'h00, pinLo, pinHi}, 8'h03); // no port latch in this block, pins seen directly
    complete_run();
  end
endmodule : tb_dual_8bit_timer_counter
